// File: rtl/output_fallback_runstop_ctrl.sv
// Discrete output fallback, cluster protection and run/stop arbitration.
// Assumes raw fault pins and switch/input pins are asynchronous to clk.
`timescale 1ns/1ps
module output_fallback_runstop_ctrl #(
  parameter int NUM_OUTPUTS = fallback_pkg::NUM_OUTPUTS,
  parameter int NUM_INPUTS = 16,
  parameter int REARM_CYCLES = fallback_pkg::REARM_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_OUTPUTS-1:0] app_value,
  input wire logic [NUM_OUTPUTS-1:0] default_value,
  input wire logic [NUM_OUTPUTS-1:0] pulse_train_output_sel,
  input wire logic [NUM_OUTPUTS-1:0] sink_type,
  input wire logic relay_type,
  input wire logic [NUM_OUTPUTS-1:0] short_low_pin,
  input wire logic [NUM_OUTPUTS-1:0] short_high_pin,
  input wire logic rearm_inhibit,
  input wire logic exception_req,
  input wire logic switch_run_pin,
  input wire logic [NUM_INPUTS-1:0] input_pins,
  input wire logic runstop_assign_req,
  input wire logic runstop_clear_req,
  input wire logic [7:0] runstop_assign_index,
  input wire logic sw_run_cmd,
  input wire logic sw_stop_cmd,
  output logic [NUM_OUTPUTS-1:0] out_drive,
  output logic [(NUM_OUTPUTS+3)/4-1:0] cluster_fault,
  output logic [1:0] ctrl_state,
  output logic runstop_configured,
  output logic [7:0] runstop_index,
  output logic runstop_assign_reject,
  output logic sw_cmd_refused
);
  localparam int NUM_CLUSTERS = (NUM_OUTPUTS + fallback_pkg::CLUSTER_SIZE - 1) /
    fallback_pkg::CLUSTER_SIZE;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_RUN,
    MODE_EXCEPTION
  } run_mode_t;

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_OUTPUTS-1:0] low_s1;
    logic [NUM_OUTPUTS-1:0] low_s2;
    logic [NUM_OUTPUTS-1:0] low_s3;
    logic [NUM_OUTPUTS-1:0] high_s1;
    logic [NUM_OUTPUTS-1:0] high_s2;
    logic [NUM_OUTPUTS-1:0] high_s3;
    logic [NUM_OUTPUTS-1:0] low_q;
    logic [NUM_OUTPUTS-1:0] high_q;
    logic [2:0] sw_sync;
    logic sw_q;
    logic [NUM_INPUTS-1:0] in_s1;
    logic [NUM_INPUTS-1:0] in_s2;
    logic [NUM_INPUTS-1:0] in_s3;
    logic [NUM_INPUTS-1:0] in_q;
    logic rs_cfg;
    logic [7:0] rs_idx;
    logic reject;
    logic refused;
    run_mode_t mode;
    logic [1:0] mode_code;
    logic [NUM_OUTPUTS-1:0] drive;
    logic [NUM_CLUSTERS-1:0] fault_flag;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [NUM_CLUSTERS-1:0] cluster_fault_seen;
  logic [NUM_CLUSTERS-1:0] cluster_blanked;
  logic [NUM_OUTPUTS-1:0] out_fault;
  logic [NUM_OUTPUTS-1:0] out_blank;

  // -------------------------------------------------------------------------
  // Fault qualification
  // -------------------------------------------------------------------------
  // Outputs 0-3 trip on either rail; higher outputs only on the stressing rail.
  always_comb begin
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      // Relay contacts carry no current sensing, so they never report a short.
      if (relay_type) begin
        out_fault[i] = 1'b0;
      end else if (i < fallback_pkg::CLUSTER_SIZE) begin
        out_fault[i] = state.low_q[i] | state.high_q[i];
      end else if (sink_type[i]) begin
        out_fault[i] = state.high_q[i];
      end else begin
        out_fault[i] = state.low_q[i];
      end
    end
    for (int c = 0; c < NUM_CLUSTERS; c++) begin
      cluster_fault_seen[c] = 1'b0;
      for (int k = 0; k < fallback_pkg::CLUSTER_SIZE; k++) begin
        if (c * fallback_pkg::CLUSTER_SIZE + k < NUM_OUTPUTS) begin
          cluster_fault_seen[c] = cluster_fault_seen[c] |
            out_fault[c * fallback_pkg::CLUSTER_SIZE + k];
        end
      end
    end
    // Blanking is per cluster, so one short silences its neighbours as well.
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      out_blank[i] = cluster_blanked[i / fallback_pkg::CLUSTER_SIZE];
    end
  end

  // -------------------------------------------------------------------------
  // Protection clusters
  // -------------------------------------------------------------------------
  // Each cluster owns its re-arm timer, so one faulted group never delays another.
  for (genvar g = 0; g < NUM_CLUSTERS; g++) begin : g_cluster
    fault_cluster #(
      .REARM_CYCLES(REARM_CYCLES)
    ) u_cluster (
      .clk(clk),
      .rst_n(rst_n),
      .fault_seen(cluster_fault_seen[g]),
      .rearm_inhibit(rearm_inhibit),
      .blanked(cluster_blanked[g])
    );
  end

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  logic sel_in;
  logic sel_in_prev;
  logic sw_stable;
  logic in_rise;
  logic cmd_allowed;
  logic [NUM_OUTPUTS-1:0] value;

  always_comb begin
    next_state = state;
    sel_in = 1'b0;
    sel_in_prev = 1'b0;
    value = '0;
    // Three-stage synchronisers; a level counts once stages two and three agree.
    next_state.low_s1 = short_low_pin;
    next_state.low_s2 = state.low_s1;
    next_state.low_s3 = state.low_s2;
    next_state.high_s1 = short_high_pin;
    next_state.high_s2 = state.high_s1;
    next_state.high_s3 = state.high_s2;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      if (state.low_s2[i] == state.low_s3[i]) begin
        next_state.low_q[i] = state.low_s3[i];
      end
      if (state.high_s2[i] == state.high_s3[i]) begin
        next_state.high_q[i] = state.high_s3[i];
      end
    end
    // The switch filter reads stop until three samples have passed after reset.
    next_state.sw_sync = {state.sw_sync[1:0], switch_run_pin};
    sw_stable = state.sw_sync[2] == state.sw_sync[1];
    if (sw_stable) begin
      next_state.sw_q = state.sw_sync[2];
    end
    next_state.in_s1 = input_pins;
    next_state.in_s2 = state.in_s1;
    next_state.in_s3 = state.in_s2;
    for (int j = 0; j < NUM_INPUTS; j++) begin
      if (state.in_s2[j] == state.in_s3[j]) begin
        next_state.in_q[j] = state.in_s3[j];
      end
      if (state.rs_cfg && state.rs_idx == 8'(j)) begin
        sel_in = next_state.in_q[j];
        sel_in_prev = state.in_q[j];
      end
    end
    // The edge is taken on filtered levels, so a glitch on the input shorter than one clock cannot retrigger RUN.
    in_rise = sel_in && !sel_in_prev;

    // One designated input at most; a second assignment is refused.
    next_state.reject = 1'b0;
    if (runstop_clear_req) begin
      next_state.rs_cfg = 1'b0;
    end else if (runstop_assign_req) begin
      if (state.rs_cfg || runstop_assign_index >= 8'(NUM_INPUTS)) begin
        next_state.reject = 1'b1;
      end else begin
        next_state.rs_cfg = 1'b1;
        next_state.rs_idx = runstop_assign_index;
      end
    end

    // Run/stop arbitration from switch, designated input and software.
    cmd_allowed = 1'b0;
    if (!next_state.sw_q) begin
      next_state.mode = MODE_STOP;
    end else if (state.rs_cfg && !sel_in) begin
      next_state.mode = MODE_STOP;
    end else if (!state.sw_q) begin
      next_state.mode = MODE_RUN;
    end else if (state.rs_cfg && in_rise) begin
      next_state.mode = MODE_RUN;
    end else begin
      cmd_allowed = 1'b1;
      // Stop wins when both commands arrive together, being the safer of the two.
      if (sw_stop_cmd) begin
        next_state.mode = MODE_STOP;
      end else if (sw_run_cmd) begin
        next_state.mode = MODE_RUN;
      end
    end
    // An exception overrides every request while raised, then holds until software, the switch or the designated input changes the mode.
    if (exception_req) begin
      next_state.mode = MODE_EXCEPTION;
    end
    next_state.refused = (sw_run_cmd | sw_stop_cmd) & !cmd_allowed;

    // The port keeps the shared encoding, whatever the enum packs to.
    case (next_state.mode)
      MODE_STOP: begin
        next_state.mode_code = fallback_pkg::CTRL_STOP;
      end
      MODE_RUN: begin
        next_state.mode_code = fallback_pkg::CTRL_RUN;
      end
      MODE_EXCEPTION: begin
        next_state.mode_code = fallback_pkg::CTRL_EXCEPTION;
      end
      default: begin
        next_state.mode_code = fallback_pkg::CTRL_STOP;
      end
    endcase

    // Output value: application value in RUN, fallback value otherwise.
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      case (state.mode)
        MODE_RUN: begin
          value[i] = app_value[i];
        end
        MODE_STOP, MODE_EXCEPTION: begin
          if (pulse_train_output_sel[i]) begin
            value[i] = fallback_pkg::PULSE_FALLBACK_VALUE[0];
          end else begin
            value[i] = default_value[i];
          end
        end
        default: begin
          value[i] = 1'b0;
        end
      endcase
      if (out_blank[i]) begin
        value[i] = 1'b0;
      end
    end
    next_state.drive = value;
    next_state.fault_flag = cluster_blanked;
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  // Reset leaves the controller stopped with every output low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  // Every port comes straight from a field of the registered state.
  assign out_drive = state.drive;
  assign cluster_fault = state.fault_flag;
  assign ctrl_state = state.mode_code;
  assign runstop_configured = state.rs_cfg;
  assign runstop_index = state.rs_idx;
  assign runstop_assign_reject = state.reject;
  assign sw_cmd_refused = state.refused;
endmodule

// File: rtl/fallback_pkg.sv
// Shared constants for the output fallback and run/stop controller.
// Assumes a 100 MHz system clock; the re-arm cycle count below derives from that rate.
package fallback_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int NUM_OUTPUTS = 16;
  localparam int CLUSTER_SIZE = 4;
  localparam int REARM_PERIOD_MS = 1000;
  localparam int REARM_CYCLES = CLK_HZ / 1000 * REARM_PERIOD_MS;
  localparam int PULSE_FALLBACK_VALUE = 0;
  localparam int FIRST_CLUSTER_FULL_SHORT_HI = 0;
  localparam logic [1:0] CTRL_STOP = 2'h0;
  localparam logic [1:0] CTRL_RUN = 2'h1;
  localparam logic [1:0] CTRL_EXCEPTION = 2'h2;
endpackage

// File: rtl/fault_cluster.sv
// One protection cluster: blanks its outputs on a fault and re-arms them after REARM_CYCLES cycles without a fault.
// Assumes a synchronised fault level from the output driver stage.
`timescale 1ns/1ps
module fault_cluster #(
  parameter int REARM_CYCLES = 100000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fault_seen,
  input wire logic rearm_inhibit,
  output logic blanked
);
  typedef struct packed {
    logic blanked;
    logic [31:0] count;
  } cluster_state_t;

  cluster_state_t state;
  cluster_state_t next_state;

  always_comb begin
    next_state = state;
    if (fault_seen) begin
      next_state.blanked = 1'b1;
      next_state.count = 32'h0;
    end else if (state.blanked && !rearm_inhibit) begin
      if (state.count >= 32'(REARM_CYCLES - 1)) begin
        // Release only on the tick: a fault still present holds the count at zero, so the cluster never releases.
        next_state.blanked = 1'b0;
        next_state.count = 32'h0;
      end else begin
        next_state.count = state.count + 32'h1;
      end
    end else begin
      next_state.count = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign blanked = state.blanked;
endmodule

// File: dv/output_fallback_runstop_ctrl_assertions.sv
// Port checks for the output fallback and run/stop controller.
// Bound to the top module; assumes 16 outputs and 16 inputs.
`timescale 1ns/1ps
module output_fallback_runstop_ctrl_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] default_value,
  input wire logic [15:0] pulse_train_output_sel,
  input wire logic relay_type,
  input wire logic rearm_inhibit,
  input wire logic exception_req,
  input wire logic switch_run_pin,
  input wire logic [15:0] input_pins,
  input wire logic sw_run_cmd,
  input wire logic sw_stop_cmd,
  input wire logic [15:0] out_drive,
  input wire logic [3:0] cluster_fault,
  input wire logic [1:0] ctrl_state,
  input wire logic runstop_configured,
  input wire logic [7:0] runstop_index,
  input wire logic sw_cmd_refused
);
  logic [15:0] blank_mask;
  assign blank_mask = {{4{cluster_fault[3]}}, {4{cluster_fault[2]}}, {4{cluster_fault[1]}},
    {4{cluster_fault[0]}}};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_fallback_value: assert property ($past(rst_n) && ctrl_state != 2'h1 &&
    $past(ctrl_state) != 2'h1 && cluster_fault == 4'h0 && $past(cluster_fault) == 4'h0 &&
    $stable(default_value) && $stable(pulse_train_output_sel)
    |-> out_drive == (default_value & ~pulse_train_output_sel)) else $error("fallback wrong");
  a_cluster_blank: assert property ((out_drive & blank_mask) == 16'h0)
    else $error("faulted cluster drives");
  a_rearm_held: assert property ($past(rst_n) && rearm_inhibit && $past(rearm_inhibit)
    && $past(rearm_inhibit, 2)
    |-> (cluster_fault & $past(cluster_fault)) == $past(cluster_fault)) else $error("rearmed");
  a_relay_quiet: assert property ((relay_type[*8] ##0 cluster_fault == 4'h0)
    |=> (!relay_type || cluster_fault == 4'h0)) else $error("relay fault raised");
  a_switch_stop: assert property (!switch_run_pin[*8] |-> ctrl_state != 2'h1)
    else $error("run with switch at stop");
  a_input_low: assert property ((runstop_configured && !input_pins[runstop_index])[*8]
    |-> ctrl_state != 2'h1) else $error("run with input low");
  a_sw_run_taken: assert property ((switch_run_pin[*8] ##0 (!runstop_configured &&
    sw_run_cmd && !sw_stop_cmd && !exception_req && ctrl_state != 2'h2)) |=> ctrl_state == 2'h1)
    else $error("run command lost");
  a_cmd_refused: assert property ((!switch_run_pin[*8] ##0 sw_run_cmd)
    |=> sw_cmd_refused) else $error("command not refused");
  c_fault: cover property (cluster_fault != 4'h0);
  c_run: cover property (ctrl_state == 2'h1);
  c_refused: cover property (sw_cmd_refused);
endmodule
bind output_fallback_runstop_ctrl output_fallback_runstop_ctrl_assertions u_chk (.*);

// File: dv/field_loads.sv
// Field side: turns commanded shorts into driver-stage fault pins.
// A short shows one clock after it is commanded, as a load settling would.
`timescale 1ns/1ps
module field_loads (
  input wire logic clk,
  input wire logic [15:0] lo_cmd,
  input wire logic [15:0] hi_cmd,
  output logic [15:0] short_low_pin,
  output logic [15:0] short_high_pin
);
  always_ff @(posedge clk) begin
    short_low_pin <= lo_cmd;
    short_high_pin <= hi_cmd;
  end
endmodule

// File: dv/output_fallback_runstop_ctrl_bench.sv
// Self-checking bench for the output fallback and run/stop controller.
// Re-arm period is shortened to 20 cycles; inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module output_fallback_runstop_ctrl_bench;
  logic clk = 1'b0, rst_n = 1'b0, relay = 1'b0, inhibit = 1'b0, exc = 1'b0, sw_pin = 1'b0;
  logic asg = 1'b0, clr = 1'b0, run_cmd = 1'b0, stop_cmd = 1'b0, cfg, reject, refused;
  logic [15:0] app = 16'hffff, dflt = 16'ha5c3, pulse_train_output = 16'h0003, sink = 16'h0, inp = 16'h0;
  logic [15:0] lo_cmd = 16'h0, hi_cmd = 16'h0, out_drive, low_pin, high_pin;
  logic [7:0] asg_idx = 8'h03, rs_idx;
  logic [3:0] cluster_fault;
  logic [1:0] ctrl_state;
  int err_total = 0, n_checks = 0;
  always #5 clk = ~clk;
  field_loads u_field (.clk(clk), .lo_cmd(lo_cmd), .hi_cmd(hi_cmd), .short_low_pin(low_pin),
    .short_high_pin(high_pin));
  output_fallback_runstop_ctrl #(.REARM_CYCLES(20)) u_dut (.clk(clk), .rst_n(rst_n),
    .app_value(app), .default_value(dflt), .pulse_train_output_sel(pulse_train_output), .sink_type(sink),
    .relay_type(relay), .short_low_pin(low_pin), .short_high_pin(high_pin),
    .rearm_inhibit(inhibit), .exception_req(exc), .switch_run_pin(sw_pin), .input_pins(inp),
    .runstop_assign_req(asg), .runstop_clear_req(clr), .runstop_assign_index(asg_idx),
    .sw_run_cmd(run_cmd), .sw_stop_cmd(stop_cmd), .out_drive(out_drive),
    .cluster_fault(cluster_fault), .ctrl_state(ctrl_state), .runstop_configured(cfg),
    .runstop_index(rs_idx), .runstop_assign_reject(reject), .sw_cmd_refused(refused));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // Applies shorts, checks blanking, removes them and checks the outcome of re-arming.
  task automatic short_case(input logic [15:0] lo, hi, input logic [3:0] exp, after);
    logic [15:0] m;
    for (int i = 0; i < 16; i++) begin
      m[i] = exp[i / 4];
    end
    lo_cmd = lo;
    hi_cmd = hi;
    tick(12);
    `CHK("cluster_fault", exp, cluster_fault)
    `CHK("blanked_drive", ~m, out_drive)
    lo_cmd = 16'h0;
    hi_cmd = 16'h0;
    tick(45);
    `CHK("rearmed_fault", after, cluster_fault)
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // The whole sequence needs under 900 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(10);
    `CHK("stop_drive", 16'ha5c0, out_drive)
    sw_pin = 1'b1;
    tick(10);
    `CHK("switch_run", 2'h1, ctrl_state)
    `CHK("run_drive", 16'hffff, out_drive)
    pulse(stop_cmd);
    `CHK("sw_stop", 2'h0, ctrl_state)
    pulse(run_cmd);
    `CHK("sw_run", 2'h1, ctrl_state)
    exc = 1'b1;
    tick(3);
    exc = 1'b0;
    `CHK("exc_state", 2'h2, ctrl_state)
    `CHK("exc_drive", 16'ha5c0, out_drive)
    sw_pin = 1'b0;
    tick(10);
    pulse(run_cmd);
    `CHK("refused_at_stop", 1'b1, refused)
    `CHK("stop_held", 2'h0, ctrl_state)
    sw_pin = 1'b1;
    tick(10);
    short_case(16'h0020, 16'h0, 4'h2, 4'h0);
    short_case(16'h0, 16'h0040, 4'h0, 4'h0);
    inhibit = 1'b1;
    short_case(16'h0, 16'h0001, 4'h1, 4'h1);
    inhibit = 1'b0;
    sink = 16'hffff;
    short_case(16'h0201, 16'h0, 4'h1, 4'h0);
    short_case(16'h0, 16'h8200, 4'hc, 4'h0);
    relay = 1'b1;
    short_case(16'hffff, 16'hffff, 4'h0, 4'h0);
    relay = 1'b0;
    pulse(asg);
    tick(10);
    `CHK("input_cfg", 1'b1, cfg)
    `CHK("input_low_stop", 2'h0, ctrl_state)
    pulse(run_cmd);
    `CHK("refused_input_low", 1'b1, refused)
    asg_idx = 8'h05;
    pulse(asg);
    `CHK("second_assign", 1'b1, reject)
    `CHK("index_kept", 8'h03, rs_idx)
    inp = 16'h0008;
    tick(10);
    `CHK("input_rise_run", 2'h1, ctrl_state)
    pulse(stop_cmd);
    `CHK("input_high_stop", 2'h0, ctrl_state)
    pulse(clr);
    `CHK("cfg_cleared", 1'b0, cfg)
    give_verdict();
  end
endmodule
